// >>> tws_regs.vh
// Register map, field positions, reset values and timing limits of the three-wire serial block
`ifndef TWS_REGS_VH
`define TWS_REGS_VH

// Peripheral clock gate
`define TWS_OFF_GATE        12'h000
`define TWS_GATE_U0_BIT     2
`define TWS_GATE_U1_BIT     3
`define TWS_RST_GATE        8'h00

// Per-unit registers, base of unit m is UNIT0_BASE + m * UNIT_STRIDE
`define TWS_UNIT0_BASE      12'h010
`define TWS_UNIT_STRIDE     12'h020
`define TWS_U_HALT          12'h000
`define TWS_U_LAUNCH        12'h004
`define TWS_U_ENABLED       12'h008
`define TWS_U_LEVEL         12'h00C
`define TWS_U_DRIVE         12'h010
`define TWS_U_PRESC         12'h014
`define TWS_LEVEL_CLK_LSB   8
`define TWS_RST_LEVEL_BIT   1'b1
`define TWS_RST_DRIVE_BIT   1'b0
`define TWS_RST_PRESC       8'h00

// Per-channel registers, base of channel k is CH_BASE + k * CH_STRIDE
`define TWS_CH_BASE         12'h080
`define TWS_CH_STRIDE       12'h010
`define TWS_C_MODE          12'h000
`define TWS_C_CFG           12'h004
`define TWS_C_DATA          12'h008
`define TWS_C_DIV           12'h00C
// Mode fields
`define TWS_MODE_IRQSRC     0
`define TWS_MODE_CLKSEL     15
`define TWS_RST_MODE        2'b00
// Config fields
`define TWS_CFG_LEN8        0
`define TWS_CFG_LSBF        7
`define TWS_CFG_CKP         12
`define TWS_CFG_DAP         13
`define TWS_RST_CFG         4'h1
`define TWS_RST_DIV         7'h00
// Data readback flags
`define TWS_DATA_BUSY       8
`define TWS_DATA_BFULL      9

// Serial clock limits in system clock cycles per half period
`define TWS_SYS_CLK_HZ      50000000
`define TWS_MIN_HALF_FIRST  23'h00_0001
`define TWS_MIN_HALF_OTHER  23'h00_0002

`endif

// >>> tws_serial_channels.v
// Three-wire serial transmit channels with APB register access
`timescale 1ns/1ps
`include "tws_regs.vh"

// Function
// - Clearing unit enable bit 2 or 3 freezes that unit's channel logic.
// - Disabled unit ignores its register writes and reads back reset values.
// - Halt trigger clears enabled status and stops the channel; reads as zero.
// - Read-only enabled status changes only through launch and halt triggers.
// - Clock output level is software writable while the channel is halted.
// - Data output level is software writable while output drive is disabled.
// - Six channels: unit 0 channels 0-3, unit 1 channels 0-1.
// - Seven or eight bit frames, MSB or LSB first.
// - Data phase clear: data driven when the clock starts toggling.
// - Serial clock at most system/2 on first channel, system/4 elsewhere.
// - Interrupt source: transfer complete (0) or buffer empty (1).
// - Clock select picks prescaler output zero or one.
// - Master transmit generates clock and shifts data; no error flags.
// - Launch trigger bit sets that channel's enabled status.
// - Data phase set: data driven half a clock before toggling starts.
// - Data low byte write while running starts a frame if idle, else fills the one-byte buffer.
module tws_serial_channels #(
  parameter NCH = 6
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        reset,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // Serial pins
  output wire [5:0]  sclk_o,
  output wire [5:0]  sdo_o,
  // Per-channel event pulses
  output wire [5:0]  chan_irq_o
);

  localparam ST_IDLE  = 2'b00;
  localparam ST_LEAD  = 2'b01;
  localparam ST_SHIFT = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake and clock gate

  reg  [7:0]  gate_q;
  reg         rd_hit;
  reg  [31:0] rd_val;
  reg  [11:0] ub;
  reg  [11:0] cb;
  integer     i;
  integer     j;
  wire        acc     = psel & penable & pready;
  wire        wr_en   = acc & pwrite;
  wire [1:0]  unit_on = {gate_q[`TWS_GATE_U1_BIT], gate_q[`TWS_GATE_U0_BIT]};

  // Per-channel state gathered for readback
  wire [5:0]  en_v;
  wire [5:0]  clk_v;
  wire [5:0]  dat_v;
  wire [5:0]  oe_v;
  wire [5:0]  busy_v;
  wire [5:0]  bfull_v;
  wire [11:0] mode_v;
  wire [23:0] cfg_v;
  wire [41:0] div_v;
  wire [47:0] data_v;
  reg  [15:0] presc_q;

  // One wait state: answer on the cycle after the access phase opens
  always @(posedge clk_sys) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_val : 32'h0000_0000;
      pslverr <= psel & penable & ~pready & ~rd_hit;
    end
  end

  // Clock gate register
  always @(posedge clk_sys) begin
    if (reset) begin
      gate_q <= `TWS_RST_GATE;
    end else if (wr_en && paddr == `TWS_OFF_GATE) begin
      gate_q <= pwdata[7:0];
    end
  end

  // Prescaler settings, one byte per unit
  always @(posedge clk_sys) begin
    if (reset) begin
      presc_q <= {2{`TWS_RST_PRESC}};
    end else begin
      for (j = 0; j < 2; j = j + 1) begin
        if (wr_en && unit_on[j] &&
            paddr == `TWS_UNIT0_BASE + j[11:0] * `TWS_UNIT_STRIDE + `TWS_U_PRESC) begin
          presc_q[j*8 +: 8] <= pwdata[7:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode

  // Units that are gated off read back their reset values
  always @* begin
    rd_hit = 1'b0;
    rd_val = 32'h0000_0000;
    ub     = 12'h000;
    cb     = 12'h000;
    if (paddr == `TWS_OFF_GATE) begin
      rd_hit = 1'b1;
      rd_val = {24'h00_0000, gate_q};
    end
    for (i = 0; i < 2; i = i + 1) begin
      ub = `TWS_UNIT0_BASE + i[11:0] * `TWS_UNIT_STRIDE;
      if (paddr == ub + `TWS_U_HALT || paddr == ub + `TWS_U_LAUNCH) begin
        rd_hit = 1'b1;
      end else if (paddr == ub + `TWS_U_ENABLED) begin
        rd_hit = 1'b1;
        if (unit_on[i])
          rd_val = (i == 0) ? {28'h000_0000, en_v[3:0]} : {30'h0000_0000, en_v[5:4]};
      end else if (paddr == ub + `TWS_U_LEVEL) begin
        rd_hit = 1'b1;
        if (!unit_on[i])
          rd_val = (i == 0) ? 32'h0000_0F0F : 32'h0000_0303;
        else if (i == 0)
          rd_val = {20'h0_0000, clk_v[3:0], 4'h0, dat_v[3:0]};
        else
          rd_val = {22'h00_0000, clk_v[5:4], 6'h00, dat_v[5:4]};
      end else if (paddr == ub + `TWS_U_DRIVE) begin
        rd_hit = 1'b1;
        if (unit_on[i])
          rd_val = (i == 0) ? {28'h000_0000, oe_v[3:0]} : {30'h0000_0000, oe_v[5:4]};
      end else if (paddr == ub + `TWS_U_PRESC) begin
        rd_hit = 1'b1;
        if (unit_on[i])
          rd_val = {24'h00_0000, presc_q[i*8 +: 8]};
      end
    end
    for (i = 0; i < NCH; i = i + 1) begin
      cb = `TWS_CH_BASE + i[11:0] * `TWS_CH_STRIDE;
      if (paddr == cb + `TWS_C_MODE) begin
        rd_hit = 1'b1;
        if (unit_on[i >= 4])
          rd_val = {16'h0000, mode_v[i*2+1], 14'h0000, mode_v[i*2]};
      end else if (paddr == cb + `TWS_C_CFG) begin
        rd_hit = 1'b1;
        rd_val = {18'h0_0000, cfg_v[i*4+3], cfg_v[i*4+2], 4'h0, cfg_v[i*4+1],
                  6'h00, cfg_v[i*4]};
        if (!unit_on[i >= 4])
          rd_val = {28'h000_0000, (`TWS_RST_CFG >> `TWS_CFG_LEN8) & 4'h1};
      end else if (paddr == cb + `TWS_C_DATA) begin
        rd_hit = 1'b1;
        if (unit_on[i >= 4])
          rd_val = {22'h00_0000, bfull_v[i], busy_v[i], data_v[i*8 +: 8]};
      end else if (paddr == cb + `TWS_C_DIV) begin
        rd_hit = 1'b1;
        if (unit_on[i >= 4])
          rd_val = {25'h000_0000, div_v[i*7 +: 7]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  genvar k;
  generate
    for (k = 0; k < NCH; k = k + 1) begin : g_ch
      localparam U = (k >= 4) ? 1 : 0;
      localparam L = (k >= 4) ? k - 4 : k;
      localparam [11:0] UB = `TWS_UNIT0_BASE + U * `TWS_UNIT_STRIDE;
      localparam [11:0] CB = `TWS_CH_BASE + k * `TWS_CH_STRIDE;
      localparam [22:0] MIN_HALF = (k == 0) ? `TWS_MIN_HALF_FIRST : `TWS_MIN_HALF_OTHER;

      reg  [1:0]  st_q;
      reg  [22:0] cnt_q;
      reg  [3:0]  ph_q;
      reg  [7:0]  sh_q;
      reg  [7:0]  buf_q;
      reg         bfull_q;
      reg         irq_q;
      reg         en_q;
      reg         clk_q;
      reg         dat_q;
      reg         oe_q;
      reg  [1:0]  mode_q;
      reg  [3:0]  cfg_q;
      reg  [6:0]  div_q;

      wire        uw     = wr_en & unit_on[U];
      wire        dap    = cfg_q[3];
      wire        lsbf   = cfg_q[1];
      wire        len8   = cfg_q[0];
      wire [3:0]  p_exp  = mode_q[1] ? presc_q[U*8+4 +: 4] : presc_q[U*8 +: 4];
      wire [22:0] half_r = {15'h0000, {1'b0, div_q} + 8'h01} << p_exp;
      wire [22:0] half   = (half_r < MIN_HALF) ? MIN_HALF : half_r;
      wire        tick   = (cnt_q >= half - 23'h00_0001);
      wire [3:0]  last   = len8 ? 4'hF : 4'hD;
      // Bit on the line now, and after the next shift
      wire        fb     = lsbf ? sh_q[0] : (len8 ? sh_q[7] : sh_q[6]);
      wire        nb     = lsbf ? sh_q[1] : (len8 ? sh_q[6] : sh_q[5]);
      wire [7:0]  wb     = pwdata[7:0];
      wire        wfb    = cfg_q[1] ? wb[0] : (len8 ? wb[7] : wb[6]);
      wire        bfb    = lsbf ? buf_q[0] : (len8 ? buf_q[7] : buf_q[6]);

      assign en_v[k]         = en_q;
      assign clk_v[k]        = clk_q;
      assign dat_v[k]        = dat_q;
      assign oe_v[k]         = oe_q;
      assign busy_v[k]       = (st_q != ST_IDLE);
      assign bfull_v[k]      = bfull_q;
      assign mode_v[k*2 +: 2] = mode_q;
      assign cfg_v[k*4 +: 4] = cfg_q;
      assign div_v[k*7 +: 7] = div_q;
      assign data_v[k*8 +: 8] = buf_q;
      assign sclk_o[k]       = clk_q;
      assign sdo_o[k]        = dat_q;
      assign chan_irq_o[k]   = irq_q;

      // Software-owned configuration
      always @(posedge clk_sys) begin
        if (reset) begin
          mode_q <= `TWS_RST_MODE;
          cfg_q  <= `TWS_RST_CFG;
          div_q  <= `TWS_RST_DIV;
          oe_q   <= `TWS_RST_DRIVE_BIT;
        end else begin
          if (uw && paddr == CB + `TWS_C_MODE)
            mode_q <= {pwdata[`TWS_MODE_CLKSEL], pwdata[`TWS_MODE_IRQSRC]};
          if (uw && paddr == CB + `TWS_C_CFG)
            cfg_q <= {pwdata[`TWS_CFG_DAP], pwdata[`TWS_CFG_CKP],
                      pwdata[`TWS_CFG_LSBF], pwdata[`TWS_CFG_LEN8]};
          if (uw && paddr == CB + `TWS_C_DIV)
            div_q <= pwdata[6:0];
          if (uw && paddr == UB + `TWS_U_DRIVE)
            oe_q <= pwdata[L];
        end
      end

      // Enabled status, pin levels and the transmit engine
      always @(posedge clk_sys) begin
        if (reset) begin
          en_q    <= 1'b0;
          clk_q   <= `TWS_RST_LEVEL_BIT;
          dat_q   <= `TWS_RST_LEVEL_BIT;
          st_q    <= ST_IDLE;
          cnt_q   <= 23'h00_0000;
          ph_q    <= 4'h0;
          sh_q    <= 8'h00;
          buf_q   <= 8'h00;
          bfull_q <= 1'b0;
          irq_q   <= 1'b0;
        end else begin
          irq_q <= 1'b0;
          // Direct level writes: clock only while halted, data only while drive is disabled
          if (uw && paddr == UB + `TWS_U_LEVEL) begin
            if (!en_q)
              clk_q <= pwdata[`TWS_LEVEL_CLK_LSB + L];
            if (!oe_q)
              dat_q <= pwdata[L];
          end
          if (unit_on[U]) begin
            // Engine: one half period per tick, clock toggles each tick in the shift state
            case (st_q)
              ST_LEAD: begin
                cnt_q <= cnt_q + 23'h00_0001;
                if (tick) begin
                  st_q  <= ST_SHIFT;
                  cnt_q <= half - 23'h00_0001;
                end
              end
              ST_SHIFT: begin
                cnt_q <= cnt_q + 23'h00_0001;
                if (tick) begin
                  cnt_q <= 23'h00_0000;
                  ph_q  <= ph_q + 4'h1;
                  clk_q <= ~clk_q;
                  if (!ph_q[0]) begin
                    if (!dap)
                      dat_q <= fb;
                  end else begin
                    sh_q <= lsbf ? {1'b0, sh_q[7:1]} : {sh_q[6:0], 1'b0};
                    if (dap && ph_q != last)
                      dat_q <= nb;
                    if (ph_q == last) begin
                      ph_q <= 4'h0;
                      if (!mode_q[0])
                        irq_q <= 1'b1;
                      if (bfull_q) begin
                        sh_q    <= buf_q;
                        bfull_q <= 1'b0;
                        irq_q   <= 1'b1; // Buffer empty or frame end, either way
                        st_q    <= dap ? ST_LEAD : ST_SHIFT;
                        if (dap)
                          dat_q <= bfb;
                      end else begin
                        st_q <= ST_IDLE;
                      end
                    end
                  end
                end
              end
              default: begin
                cnt_q <= 23'h00_0000;
                ph_q  <= 4'h0;
              end
            endcase
            // Data write while running starts or queues a frame
            if (uw && paddr == CB + `TWS_C_DATA) begin
              buf_q <= wb;
              if (en_q) begin
                if (st_q == ST_IDLE) begin
                  sh_q  <= wb;
                  cnt_q <= 23'h00_0000;
                  ph_q  <= 4'h0;
                  st_q  <= dap ? ST_LEAD : ST_SHIFT;
                  irq_q <= mode_q[0];
                  if (dap)
                    dat_q <= wfb;
                end else begin
                  bfull_q <= 1'b1;
                end
              end
            end
            // Launch then halt, halt wins when both hit together
            if (uw && paddr == UB + `TWS_U_LAUNCH && pwdata[L])
              en_q <= 1'b1;
            if (uw && paddr == UB + `TWS_U_HALT && pwdata[L]) begin
              en_q    <= 1'b0;
              st_q    <= ST_IDLE;
              bfull_q <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

endmodule // tws_serial_channels

// >>> tws_checker.sv
// Port assertions for the three-wire serial channel block
`timescale 1ns/1ps
module tws_checker (
  // Clock and reset
  input wire        clk_sys,
  input wire        reset,
  // APB slave
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  // Serial pins and events
  input wire [5:0]  sclk_o,
  input wire [5:0]  sdo_o,
  input wire [5:0]  chan_irq_o
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // Bus answer timing and content
  a_ready_latency: assert property (psel && penable && !pready |=> pready)
    else $error("pready did not follow the access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero outside answer");
  a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("pslverr without pready or with data");
  // Pin and event behaviour
  a_irq_one_cycle: assert property (|chan_irq_o |=> (chan_irq_o & $past(chan_irq_o)) == 6'h00)
    else $error("channel event longer than one cycle");
  a_reset_levels: assert property ($fell(reset) |-> sclk_o == 6'h3f && sdo_o == 6'h3f)
    else $error("pins not high after reset");
  a_reset_quiet: assert property ($fell(reset) |-> chan_irq_o == 6'h00)
    else $error("event during reset");
  a_clk_half_min: assert property ($changed(sclk_o[1]) |=> $stable(sclk_o[1]))
    else $error("second channel clock faster than quarter rate");
endmodule // tws_checker

bind tws_serial_channels tws_checker u_checker (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .sclk_o(sclk_o), .sdo_o(sdo_o), .chan_irq_o(chan_irq_o)
);

// >>> tws_slave_model.sv
// Behavioural external slave listening on one channel's clock and data lines
`timescale 1ns/1ps
module tws_slave_model (
  // Serial lines from the master
  input  wire         sclk,
  input  wire         sdo,
  // Captured bits
  output logic [31:0] shift_q,
  output int unsigned bits_q
);
  // Start empty
  initial begin
    shift_q = 32'h0000_0000;
    bits_q  = 0;
  end

  // Sample on rising clock, normal phase, bits kept in arrival order
  always @(posedge sclk) begin
    shift_q <= {shift_q[30:0], sdo};
    bits_q  <= bits_q + 1;
  end
endmodule // tws_slave_model

// >>> testbench.sv
// Self-checking testbench for the three-wire serial channel block
`timescale 1ns/1ps
`include "tws_regs.vh"
module testbench;
  localparam logic [11:0] U0 = `TWS_UNIT0_BASE;
  localparam logic [11:0] U1 = `TWS_UNIT0_BASE + `TWS_UNIT_STRIDE;
  localparam logic [11:0] C0 = `TWS_CH_BASE;

  // Design signals
  logic        clk_sys, reset, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, er;
  logic [5:0]  sclk_o, sdo_o, chan_irq_o;
  logic [31:0] cap;
  int unsigned nbits, b0;
  int          failures, n_compared;

  tws_serial_channels DUT (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sclk_o(sclk_o), .sdo_o(sdo_o), .chan_irq_o(chan_irq_o)
  );
  tws_slave_model u_slave (.sclk(sclk_o[0]), .sdo(sdo_o[0]), .shift_q(cap), .bits_q(nbits));

  // Clock and time-zero values
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task test_done;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One APB transfer, answer taken at the rising edge where pready is high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask

  // Wait for a channel 0 event, the watchdog bounds it
  task wait_irq;
    do @(posedge clk_sys); while (chan_irq_o[0] !== 1'b1);
  endtask

  // One frame on channel 0, checked at the slave
  task send(input logic [31:0] cfg, input logic [7:0] d, input int unsigned nb,
            input logic [7:0] exp);
    apb(1, C0 + `TWS_C_CFG, cfg);
    b0 = nbits;
    apb(1, C0 + `TWS_C_DATA, {24'h00_0000, d});
    wait_irq;
    repeat (4) @(posedge clk_sys);
    chk(nbits - b0, nb);
    chk(cap & ((32'h0000_0001 << nb) - 1), {24'h00_0000, exp});
  endtask

  // Watchdog
  initial begin
    #(20 * 30000);
    failures++;
    test_done;
  end

  // Main sequence
  initial begin
    failures = 0; n_compared = 0;
    reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    repeat (16) @(posedge clk_sys);
    reset <= 0;
    apb(0, `TWS_OFF_GATE, 0); chk(rd, 32'h0000_0000);
    apb(0, U0 + `TWS_U_LEVEL, 0); chk(rd, 32'h0000_0f0f);
    apb(1, U0 + `TWS_U_LEVEL, 0);
    apb(0, U0 + `TWS_U_LEVEL, 0); chk(rd, 32'h0000_0f0f);
    chk(sdo_o, 6'h3f);
    apb(0, 12'hffc, 0); chk(er, 1'b1);
    // Unit 0 on, unit 1 still gated, so its launch is lost
    apb(1, `TWS_OFF_GATE, 32'h0000_0004);
    apb(1, U1 + `TWS_U_LAUNCH, 1);
    apb(0, U1 + `TWS_U_ENABLED, 0); chk(rd, 32'h0000_0000);
    apb(1, `TWS_OFF_GATE, 32'h0000_000c);
    apb(0, U1 + `TWS_U_ENABLED, 0); chk(rd, 32'h0000_0000);
    // Direct level writes while halted and undriven
    apb(1, U0 + `TWS_U_LEVEL, 32'h0000_0f0e);
    @(posedge clk_sys);
    chk(sdo_o[0], 1'b0);
    apb(0, U0 + `TWS_U_LEVEL, 0); chk(rd, 32'h0000_0f0e);
    apb(1, U0 + `TWS_U_LEVEL, 32'h0000_0d0f);
    @(posedge clk_sys);
    chk(sclk_o[1], 1'b0);
    apb(1, U0 + `TWS_U_LEVEL, 32'h0000_0f0f);
    // Launch channel 0 for master transmit; driven data ignores level writes
    apb(1, U0 + `TWS_U_DRIVE, 1);
    apb(1, U0 + `TWS_U_LEVEL, 32'h0000_0f0e);
    @(posedge clk_sys);
    chk(sdo_o[0], 1'b1);
    apb(1, U0 + `TWS_U_LAUNCH, 1);
    apb(0, U0 + `TWS_U_ENABLED, 0); chk(rd, 32'h0000_0001);
    send(32'h0000_0001, 8'ha5, 8, 8'ha5);
    // Second byte queued behind the first
    b0 = nbits;
    apb(1, C0 + `TWS_C_DATA, 32'h0000_003c);
    apb(1, C0 + `TWS_C_DATA, 32'h0000_00c3);
    wait_irq;
    wait_irq;
    repeat (4) @(posedge clk_sys);
    chk(nbits - b0, 16);
    chk(cap[15:0], 16'h3cc3);
    // Gating unit 0 mid-frame freezes its pins and hides its state
    b0 = nbits;
    apb(1, C0 + `TWS_C_DATA, 32'h0000_00f0);
    apb(1, `TWS_OFF_GATE, 32'h0000_0008);
    @(posedge clk_sys);
    rd = {20'h0_0000, sclk_o, sdo_o};
    repeat (8) @(posedge clk_sys);
    chk({20'h0_0000, sclk_o, sdo_o}, rd);
    apb(0, U0 + `TWS_U_ENABLED, 0); chk(rd, 32'h0000_0000);
    apb(1, `TWS_OFF_GATE, 32'h0000_000c);
    wait_irq;
    repeat (4) @(posedge clk_sys);
    chk(nbits - b0, 8);
    chk(cap[7:0], 8'hf0);
    send(32'h0000_0080, 8'h75, 7, 8'h57);
    // Data half a clock early with data phase set
    apb(1, C0 + `TWS_C_CFG, 32'h0000_2001);
    apb(1, C0 + `TWS_C_DATA, 32'h0000_0000);
    @(posedge clk_sys);
    chk({sclk_o[0], sdo_o[0]}, 2'b10);
    wait_irq;
    // Buffer-empty event while the frame still shifts
    apb(1, C0 + `TWS_C_MODE, 1);
    apb(1, C0 + `TWS_C_DATA, 32'h0000_0081);
    wait_irq;
    apb(0, C0 + `TWS_C_DATA, 0); chk(rd[8], 1'b1);
    apb(1, C0 + `TWS_C_MODE, 0);
    repeat (40) @(posedge clk_sys);
    // Halt stops the channel
    apb(1, U0 + `TWS_U_HALT, 1);
    apb(0, U0 + `TWS_U_ENABLED, 0); chk(rd, 32'h0000_0000);
    apb(0, U0 + `TWS_U_HALT, 0); chk(rd, 32'h0000_0000);
    b0 = nbits;
    apb(1, C0 + `TWS_C_DATA, 32'h0000_0055);
    repeat (40) @(posedge clk_sys);
    chk(nbits - b0, 0);
    test_done;
  end
endmodule // testbench
